// [src/pcms_defs.svh]
// constants for the pulse counter mode selector
// assumes a 25 MHz system clock
`ifndef PCMS_DEFS_SVH
`define PCMS_DEFS_SVH
`define PCMS_CLK_PERIOD_NS   40
`define PCMS_CLK_MHZ         25
`define PCMS_NKEY            8
`define PCMS_K_AUTO          0
`define PCMS_K_MANUAL        1
`define PCMS_K_LO50          2
`define PCMS_K_HIGHZ         3
`define PCMS_K_FREQ          4
`define PCMS_K_WIDTH         5
`define PCMS_K_REP           6
`define PCMS_K_TRIG          7
`define PCMS_DEBOUNCE_US     5000
`define PCMS_DEBOUNCE_CYC    (`PCMS_DEBOUNCE_US * `PCMS_CLK_MHZ)
`define PCMS_DBW             17
`define PCMS_PROF_STEP_NS    1000
`define PCMS_PROF_STEP_CYC   (`PCMS_PROF_STEP_NS / `PCMS_CLK_PERIOD_NS)
`define PCMS_NSAMP           8
`define PCMS_RATE_GATE_S     1
`define PCMS_RATE_GATE_CYC   (`PCMS_RATE_GATE_S * `PCMS_CLK_MHZ * 1000000)
`define PCMS_IN1_MIN_HZ      36'h0_1DCD_6500
`define PCMS_IN1_MAX_HZ      36'h9_502F_9000
`define PCMS_LO50_MIN_HZ     36'h0_0098_9680
`define PCMS_LO50_MAX_HZ     36'h0_1F4A_DD40
`define PCMS_HIGHZ_MIN_HZ    36'h0_0000_000A
`define PCMS_HIGHZ_MAX_HZ    36'h0_04C4_B400
`define PCMS_A_CTRL          8'h00
`define PCMS_A_STATUS        8'h04
`define PCMS_A_HIGH          8'h08
`define PCMS_A_GAP           8'h0C
`define PCMS_A_INTERVAL      8'h10
`define PCMS_A_RATE          8'h14
`define PCMS_A_SAMP_BASE     8'h20
`define PCMS_A_SAMP_MASK     8'hE0
`define PCMS_CTRL_SUPPRESS   0
`define PCMS_CTRL_TABLE      1
`define PCMS_CTRL_FORCE      2
`define PCMS_CTRL_RESET      3'h7
`endif

// [src/pcms_pkg.sv]
// types for the pulse counter mode selector
// assumes the constants header is on the include path
package pcms_pkg;
  `include "pcms_defs.svh"
  typedef enum logic [3:0] {
    MODE_AUTO   = 4'b0001,
    MODE_MANUAL = 4'b0010,
    MODE_LOW50  = 4'b0100,
    MODE_HIGHZ  = 4'b1000
  } pcms_mode_t;
  typedef enum logic [5:0] {
    FN_FREQ     = 6'b00_0001,
    FN_PROFILE  = 6'b00_0010,
    FN_WIDTH    = 6'b00_0100,
    FN_GAP      = 6'b00_1000,
    FN_INTERVAL = 6'b01_0000,
    FN_RATE     = 6'b10_0000
  } pcms_func_t;
  typedef enum logic [2:0] {
    PROF_IDLE  = 3'b001,
    PROF_RUN   = 3'b010,
    PROF_PRINT = 3'b100
  } pcms_prof_t;
  typedef enum logic [1:0] {
    MSG_NONE      = 2'h0,
    MSG_PROFILING = 2'h1,
    MSG_PLOT      = 2'h2,
    MSG_TABLE     = 2'h3
  } pcms_msg_t;
  typedef struct packed {
    logic        prev;
    logic        seen_rise;
    logic        seen_fall;
    logic [31:0] hi_cnt;
    logic [31:0] lo_cnt;
    logic [31:0] per_cnt;
    logic [31:0] win_cnt;
    logic [31:0] edge_cnt;
    logic [31:0] high;
    logic [31:0] gap;
    logic [31:0] interval;
    logic [31:0] rate;
    logic        rise;
  } pcms_tmr_st_t;
  typedef struct packed {
    logic [`PCMS_NKEY-1:0]                 sync1;
    logic [`PCMS_NKEY-1:0]                 sync2;
    logic [`PCMS_NKEY-1:0]                 stable;
    logic [`PCMS_NKEY-1:0]                 prev;
    logic [`PCMS_NKEY-1:0][`PCMS_DBW-1:0]  db_cnt;
    logic                                  det_s1;
    logic                                  det_s2;
    logic                                  pul_s1;
    logic                                  pul_s2;
    pcms_mode_t                            mode;
    pcms_func_t                            func;
    logic                                  mem_freq;
    logic                                  mem_width;
    logic                                  mem_rep;
    pcms_prof_t                            prof;
    logic [2:0]                            samp_idx;
    logic [15:0]                           samp_cnt;
    logic [`PCMS_NSAMP-1:0][31:0]          samples;
    logic [2:0]                            ctl;
    logic                                  use_in2;
    logic [35:0]                           rmin;
    logic [35:0]                           rmax;
    logic                                  meas_active;
    logic [31:0]                           rdata;
  } pcms_sel_st_t;
endpackage

// [src/pcms_pulse_timer.sv]
// pulse envelope timer: high time, gap, interval, rate
// assumes i_pulse is already synchronised to i_clk_sys
`timescale 1ns/1ns
`include "pcms_defs.svh"
module pcms_pulse_timer #(
  parameter logic [31:0] GATE_CYC = `PCMS_RATE_GATE_CYC
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  input  wire logic        i_enable,
  input  wire logic        i_pulse,
  output logic             o_rise,
  output logic [31:0]      o_high,
  output logic [31:0]      o_gap,
  output logic [31:0]      o_interval,
  output logic [31:0]      o_rate
);
  import pcms_pkg::*;
  pcms_tmr_st_t r;
  pcms_tmr_st_t next_r;
  logic rise;
  logic fall;

  always_comb begin
    next_r = r;
    rise = i_enable & i_pulse & ~r.prev;
    fall = i_enable & ~i_pulse & r.prev;
    next_r.prev = i_pulse;
    next_r.rise = rise;
    next_r.hi_cnt = i_pulse ? r.hi_cnt + 32'h0000_0001 : 32'h0000_0000;
    next_r.lo_cnt = i_pulse ? 32'h0000_0000 : r.lo_cnt + 32'h0000_0001;
    next_r.per_cnt = rise ? 32'h0000_0001 : r.per_cnt + 32'h0000_0001;
    if (fall && r.seen_rise) begin
      next_r.high = r.hi_cnt;
    end
    if (rise && r.seen_fall) begin
      next_r.gap = r.lo_cnt;
    end
    if (rise && r.seen_rise) begin
      next_r.interval = r.per_cnt;
    end
    if (rise) begin
      next_r.seen_rise = 1'b1;
    end
    if (fall && r.seen_rise) begin
      next_r.seen_fall = 1'b1;
    end
    // whole-second gate, so the edge count is already in hertz
    if (r.win_cnt == GATE_CYC - 32'h0000_0001) begin
      next_r.win_cnt = 32'h0000_0000;
      next_r.rate = r.edge_cnt + {31'h0000_0000, rise};
      next_r.edge_cnt = 32'h0000_0000;
    end else begin
      next_r.win_cnt = r.win_cnt + 32'h0000_0001;
      next_r.edge_cnt = r.edge_cnt + {31'h0000_0000, rise};
    end
    if (!i_enable) begin
      next_r.seen_rise = 1'b0;
      next_r.seen_fall = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign o_rise = r.rise;
  assign o_high = r.high;
  assign o_gap = r.gap;
  assign o_interval = r.interval;
  assign o_rate = r.rate;
endmodule

// [src/pcms_selector.sv]
// front-panel mode and pulse function selector with profile sequencer
// assumes raw key levels and pulse pins, register port on i_clk_sys
// How it works
// - low-impedance mode uses input 2, range 10 MHz to 525 MHz
// - high-impedance mode uses input 2, range 10 Hz to 80 MHz
// - modes exclusive; pressing the active mode key again changes nothing
// - six pulse functions on three keys, each key toggling its pair
// - each paired key recalls its last selected function
// - frequency key activates frequency; second press starts profiling
// - pulse functions active only with pulse detected or forced
// - frequency function is on after power-up
// - high duration is leading edge to trailing edge of one pulse
// - gap is trailing edge to next leading edge
// - interval is leading edge to next leading edge
// - rate is pulses per second in hertz
// - profile records carrier frequency across the pulse
// - show profiling message, then printing message during output
// - pulse measurements only on microwave input, 500 MHz upward
// - defaults only on power-on reset, not on leaving standby
// - power-up display suppresses kilohertz and hertz digits
// - automatic acquisition mode entered at power-up
`timescale 1ns/1ns
`include "pcms_defs.svh"
module pcms_selector #(
  parameter logic [`PCMS_DBW-1:0] DEBOUNCE_CYC = `PCMS_DEBOUNCE_CYC,
  parameter logic [31:0]          RATE_GATE_CYC = `PCMS_RATE_GATE_CYC
) (
  input  wire logic                    i_clk_sys,
  input  wire logic                    i_rst,
  input  wire logic [`PCMS_NKEY-1:0]   i_key,
  input  wire logic                    i_pulse_det,
  input  wire logic                    i_pulse_env,
  input  wire logic [31:0]             i_carrier_khz,
  input  wire logic                    i_hold,
  input  wire logic                    i_standby,
  input  wire logic                    i_print_done,
  input  wire logic [7:0]              i_addr,
  input  wire logic [31:0]             i_wdata,
  input  wire logic                    i_we,
  input  wire logic                    i_re,
  output logic [31:0]                  o_rdata,
  output pcms_pkg::pcms_mode_t         o_mode,
  output pcms_pkg::pcms_func_t         o_func,
  output pcms_pkg::pcms_msg_t          o_msg,
  output logic                         o_key_locked,
  output logic                         o_use_input2,
  output logic [35:0]                  o_range_min_hz,
  output logic [35:0]                  o_range_max_hz,
  output logic                         o_meas_active,
  output logic                         o_suppress_low_digits
);
  import pcms_pkg::*;
  pcms_sel_st_t r;
  pcms_sel_st_t next_r;
  logic [`PCMS_NKEY-1:0] strobe;
  logic        lock;
  logic        t_rise;
  logic [31:0] t_high;
  logic [31:0] t_gap;
  logic [31:0] t_interval;
  logic [31:0] t_rate;

  // leaving standby is not a reset: state is simply kept
  assign lock = (r.prof == PROF_PRINT) | i_standby;
  assign strobe = r.stable & ~r.prev;

  pcms_pulse_timer #(
    .GATE_CYC (RATE_GATE_CYC)
  ) u_timer (
    .i_clk_sys  (i_clk_sys),
    .i_rst      (i_rst),
    .i_enable   (~r.use_in2),
    .i_pulse    (r.pul_s2),
    .o_rise     (t_rise),
    .o_high     (t_high),
    .o_gap      (t_gap),
    .o_interval (t_interval),
    .o_rate     (t_rate)
  );

  always_comb begin
    next_r = r;
    next_r.sync1 = i_key;
    next_r.sync2 = r.sync1;
    next_r.prev = r.stable;
    next_r.det_s1 = i_pulse_det;
    next_r.det_s2 = r.det_s1;
    next_r.pul_s1 = i_pulse_env;
    next_r.pul_s2 = r.pul_s1;
    // a level must hold steady for the whole window before it counts
    for (int k = 0; k < `PCMS_NKEY; k++) begin
      if (r.sync2[k] == r.stable[k]) begin
        next_r.db_cnt[k] = '0;
      end else if (r.db_cnt[k] == DEBOUNCE_CYC - 1'b1) begin
        next_r.db_cnt[k] = '0;
        next_r.stable[k] = r.sync2[k];
      end else begin
        next_r.db_cnt[k] = r.db_cnt[k] + 1'b1;
      end
    end
    if (!lock) begin
      if (strobe[`PCMS_K_AUTO]) next_r.mode = MODE_AUTO;
      if (strobe[`PCMS_K_MANUAL]) next_r.mode = MODE_MANUAL;
      if (strobe[`PCMS_K_LO50]) next_r.mode = MODE_LOW50;
      if (strobe[`PCMS_K_HIGHZ]) next_r.mode = MODE_HIGHZ;
      if (strobe[`PCMS_K_FREQ]) begin
        if (r.func == FN_FREQ) begin
          next_r.func = FN_PROFILE;
          next_r.mem_freq = 1'b1;
          next_r.prof = PROF_RUN;
        end else if (r.func == FN_PROFILE) begin
          next_r.func = FN_FREQ;
          next_r.mem_freq = 1'b0;
          next_r.prof = PROF_IDLE;
        end else begin
          next_r.func = r.mem_freq ? FN_PROFILE : FN_FREQ;
        end
      end
      if (strobe[`PCMS_K_WIDTH]) begin
        if (r.func == FN_WIDTH) begin
          next_r.func = FN_GAP;
          next_r.mem_width = 1'b1;
        end else if (r.func == FN_GAP) begin
          next_r.func = FN_WIDTH;
          next_r.mem_width = 1'b0;
        end else begin
          next_r.func = r.mem_width ? FN_GAP : FN_WIDTH;
        end
      end
      if (strobe[`PCMS_K_REP]) begin
        if (r.func == FN_INTERVAL) begin
          next_r.func = FN_RATE;
          next_r.mem_rep = 1'b1;
        end else if (r.func == FN_RATE) begin
          next_r.func = FN_INTERVAL;
          next_r.mem_rep = 1'b0;
        end else begin
          next_r.func = r.mem_rep ? FN_RATE : FN_INTERVAL;
        end
      end
      if (strobe[`PCMS_K_TRIG] && i_hold && r.func == FN_PROFILE
          && r.prof == PROF_IDLE) begin
        next_r.prof = PROF_RUN;
      end
    end
    case (r.prof)
      PROF_IDLE: begin
        next_r.samp_idx = 3'h0;
        next_r.samp_cnt = 16'h0000;
      end
      PROF_RUN: begin
        // samples start at each leading edge and stop at the trailing one
        if (t_rise) begin
          next_r.samp_cnt = 16'h0000;
        end else if (r.pul_s2) begin
          if (r.samp_cnt == 16'(`PCMS_PROF_STEP_CYC - 1)) begin
            next_r.samp_cnt = 16'h0000;
            next_r.samples[r.samp_idx] = i_carrier_khz;
            next_r.samp_idx = r.samp_idx + 3'h1;
            if (r.samp_idx == 3'(`PCMS_NSAMP - 1)) begin
              next_r.prof = PROF_PRINT;
            end
          end else begin
            next_r.samp_cnt = r.samp_cnt + 16'h0001;
          end
        end
      end
      PROF_PRINT: begin
        if (i_print_done) next_r.prof = PROF_IDLE;
      end
      default: next_r.prof = PROF_IDLE;
    endcase
    next_r.use_in2 = (r.mode == MODE_LOW50) | (r.mode == MODE_HIGHZ);
    case (r.mode)
      MODE_LOW50: begin
        next_r.rmin = `PCMS_LO50_MIN_HZ;
        next_r.rmax = `PCMS_LO50_MAX_HZ;
      end
      MODE_HIGHZ: begin
        next_r.rmin = `PCMS_HIGHZ_MIN_HZ;
        next_r.rmax = `PCMS_HIGHZ_MAX_HZ;
      end
      default: begin
        next_r.rmin = `PCMS_IN1_MIN_HZ;
        next_r.rmax = `PCMS_IN1_MAX_HZ;
      end
    endcase
    next_r.meas_active = (r.det_s2 | r.ctl[`PCMS_CTRL_FORCE])
                         & ~r.use_in2;
    if (i_we && i_addr == `PCMS_A_CTRL) begin
      next_r.ctl = i_wdata[2:0];
    end
    next_r.rdata = 32'h0000_0000;
    if (i_re) begin
      if ((i_addr & `PCMS_A_SAMP_MASK) == `PCMS_A_SAMP_BASE) begin
        next_r.rdata = r.samples[i_addr[4:2]];
      end else begin
        case (i_addr)
          `PCMS_A_CTRL:     next_r.rdata = {29'h0000_0000, r.ctl};
          `PCMS_A_STATUS:   next_r.rdata = {15'h0000, r.det_s2, r.prof,
                                            r.func, r.mode, 3'h0};
          `PCMS_A_HIGH:     next_r.rdata = t_high;
          `PCMS_A_GAP:      next_r.rdata = t_gap;
          `PCMS_A_INTERVAL: next_r.rdata = t_interval;
          `PCMS_A_RATE:     next_r.rdata = t_rate;
          default:          next_r.rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      r <= '0;
      r.mode <= MODE_AUTO;
      r.func <= FN_FREQ;
      r.prof <= PROF_IDLE;
      r.ctl <= `PCMS_CTRL_RESET;
      r.rmin <= `PCMS_IN1_MIN_HZ;
      r.rmax <= `PCMS_IN1_MAX_HZ;
    end else begin
      r <= next_r;
    end
  end

  assign o_rdata = r.rdata;
  assign o_mode = r.mode;
  assign o_func = r.func;
  assign o_use_input2 = r.use_in2;
  assign o_range_min_hz = r.rmin;
  assign o_range_max_hz = r.rmax;
  assign o_meas_active = r.meas_active;
  assign o_suppress_low_digits = r.ctl[`PCMS_CTRL_SUPPRESS];
  assign o_key_locked = lock;
  assign o_msg = (r.prof == PROF_RUN) ? MSG_PROFILING :
                 (r.prof != PROF_PRINT) ? MSG_NONE :
                 r.ctl[`PCMS_CTRL_TABLE] ? MSG_TABLE : MSG_PLOT;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  a_low50_range: assert property (
    r.mode == MODE_LOW50 |=> o_use_input2 &&
      o_range_min_hz == `PCMS_LO50_MIN_HZ &&
      o_range_max_hz == `PCMS_LO50_MAX_HZ)
    else $error("low impedance range wrong");
  a_highz_range: assert property (
    r.mode == MODE_HIGHZ |=> o_use_input2 &&
      o_range_min_hz == `PCMS_HIGHZ_MIN_HZ &&
      o_range_max_hz == `PCMS_HIGHZ_MAX_HZ)
    else $error("high impedance range wrong");
  a_mode_repress: assert property (
    !lock && r.mode == MODE_HIGHZ && strobe == 8'h08 |=> $stable(r.mode))
    else $error("repeated mode key changed mode");
  a_width_toggle: assert property (
    !lock && r.func == FN_WIDTH && strobe == 8'h20 |=> r.func == FN_GAP
      ##0 r.mem_width)
    else $error("width key did not toggle");
  a_rep_recall: assert property (
    !lock && r.mem_rep && strobe == 8'h40 && r.func == FN_FREQ
      |=> r.func == FN_RATE)
    else $error("repetition key did not recall");
  a_freq_profile: assert property (
    !lock && r.func == FN_FREQ && strobe == 8'h10
      |=> r.prof == PROF_RUN && o_msg == MSG_PROFILING)
    else $error("second frequency press did not profile");
  a_meas_gate: assert property (
    !r.det_s2 && !r.ctl[`PCMS_CTRL_FORCE] |=> !o_meas_active)
    else $error("pulse function active without pulse");
  a_print_lock: assert property (
    r.prof == PROF_PRINT |-> o_key_locked && o_msg[1])
    else $error("printing without message or lock");
  a_input1_only: assert property (
    r.mode == MODE_AUTO |=> !o_use_input2 &&
      o_range_min_hz == `PCMS_IN1_MIN_HZ)
    else $error("microwave input range wrong");
  a_strobe_once: assert property (
    strobe[`PCMS_K_FREQ] |=> !strobe[`PCMS_K_FREQ])
    else $error("key strobe longer than one cycle");
endmodule

// [test/pcms_operator_model.sv]
// operator keys and pulsed microwave signal for the mode selector
// assumes key holds outlast the selector's debounce count
`timescale 1ns/1ns
module pcms_operator_model (
  input  wire logic       i_clk_sys,
  output logic [7:0]      o_key,
  output logic            o_pulse_det,
  output logic            o_pulse_env
);
  initial begin
    o_key       = 8'h00;
    o_pulse_det = 1'b0;
    o_pulse_env = 1'b0;
  end
  // one key at a time, held and released well past debounce
  task automatic press(input int k);
    @(posedge i_clk_sys);
    o_key[k] <= 1'b1;
    repeat (12) @(posedge i_clk_sys);
    o_key[k] <= 1'b0;
    repeat (12) @(posedge i_clk_sys);
  endtask
  task automatic set_det(input logic v);
    @(posedge i_clk_sys);
    o_pulse_det <= v;
  endtask
  // pulses stay wide, unchirped and fast enough for automatic mode
  task automatic burst(input int hi, input int lo, input int n);
    o_pulse_det <= 1'b1;
    repeat (n) begin
      @(posedge i_clk_sys);
      o_pulse_env <= 1'b1;
      repeat (hi) @(posedge i_clk_sys);
      o_pulse_env <= 1'b0;
      repeat (lo - 1) @(posedge i_clk_sys);
    end
  endtask
endmodule

// [test/tb_pulse_counter_mode_selector.sv]
// self-checking bench for the pulse counter mode selector
// assumes short debounce and rate gate counts chosen below
`timescale 1ns/1ns
`include "pcms_defs.svh"
module tb_pulse_counter_mode_selector;
  import pcms_pkg::*;
  logic        i_clk_sys;
  logic        i_rst;
  logic [7:0]  key;
  logic        det;
  logic        env;
  logic [31:0] i_carrier_khz;
  logic        i_hold;
  logic        i_standby;
  logic        i_print_done;
  logic [7:0]  i_addr;
  logic [31:0] i_wdata;
  logic        i_we;
  logic        i_re;
  logic [31:0] o_rdata;
  pcms_mode_t  o_mode;
  pcms_func_t  o_func;
  pcms_msg_t   o_msg;
  logic        o_key_locked;
  logic        o_use_input2;
  logic [35:0] o_range_min_hz;
  logic [35:0] o_range_max_hz;
  logic        o_meas_active;
  logic        o_suppress_low_digits;
  int          err_count;
  int          checks_done;
  pcms_mode_t  m_mode;
  pcms_func_t  m_func;
  bit          m_prof;
  bit          m_gap;
  bit          m_rate;
  logic [31:0] rv;
  int          h;
  int          mk[6] = '{2, 2, 3, 3, 1, 0};
  int          fk[7] = '{5, 5, 6, 6, 4, 6, 5};

  pcms_selector #(
    .DEBOUNCE_CYC  (17'h0_0004),
    .RATE_GATE_CYC (32'h0000_0064)
  ) dut_u (
    .i_clk_sys             (i_clk_sys),
    .i_rst                 (i_rst),
    .i_key                 (key),
    .i_pulse_det           (det),
    .i_pulse_env           (env),
    .i_carrier_khz         (i_carrier_khz),
    .i_hold                (i_hold),
    .i_standby             (i_standby),
    .i_print_done          (i_print_done),
    .i_addr                (i_addr),
    .i_wdata               (i_wdata),
    .i_we                  (i_we),
    .i_re                  (i_re),
    .o_rdata               (o_rdata),
    .o_mode                (o_mode),
    .o_func                (o_func),
    .o_msg                 (o_msg),
    .o_key_locked          (o_key_locked),
    .o_use_input2          (o_use_input2),
    .o_range_min_hz        (o_range_min_hz),
    .o_range_max_hz        (o_range_max_hz),
    .o_meas_active         (o_meas_active),
    .o_suppress_low_digits (o_suppress_low_digits)
  );
  pcms_operator_model op_u (
    .i_clk_sys   (i_clk_sys),
    .o_key       (key),
    .o_pulse_det (det),
    .o_pulse_env (env)
  );

  initial begin
    i_clk_sys = 1'b0;
    forever #20 i_clk_sys = ~i_clk_sys;
  end

  task automatic chk(input string nm, input logic [35:0] e,
                     input logic [35:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    i_we    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk_sys);
    i_re   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_re <= 1'b0;
    #1 d = o_rdata;
  endtask
  // model follows only presses the selector is expected to accept
  task automatic press(input int k, input bit live);
    op_u.press(k);
    if (live) begin
      case (k)
        `PCMS_K_AUTO:   m_mode = MODE_AUTO;
        `PCMS_K_MANUAL: m_mode = MODE_MANUAL;
        `PCMS_K_LO50:   m_mode = MODE_LOW50;
        `PCMS_K_HIGHZ:  m_mode = MODE_HIGHZ;
        `PCMS_K_FREQ: begin
          if (m_func inside {FN_FREQ, FN_PROFILE})
            m_prof = !m_prof;
          m_func = m_prof ? FN_PROFILE : FN_FREQ;
        end
        `PCMS_K_WIDTH: begin
          if (m_func inside {FN_WIDTH, FN_GAP})
            m_gap = !m_gap;
          m_func = m_gap ? FN_GAP : FN_WIDTH;
        end
        `PCMS_K_REP: begin
          if (m_func inside {FN_INTERVAL, FN_RATE})
            m_rate = !m_rate;
          m_func = m_rate ? FN_RATE : FN_INTERVAL;
        end
        default: ;
      endcase
    end
    chk("mode", m_mode, o_mode);
    chk("func", m_func, o_func);
  endtask
  task automatic chk_range();
    chk("input2", m_mode inside {MODE_LOW50, MODE_HIGHZ},
        o_use_input2);
    chk("min", m_mode == MODE_LOW50 ? `PCMS_LO50_MIN_HZ :
        m_mode == MODE_HIGHZ ? `PCMS_HIGHZ_MIN_HZ : `PCMS_IN1_MIN_HZ,
        o_range_min_hz);
    chk("max", m_mode == MODE_LOW50 ? `PCMS_LO50_MAX_HZ :
        m_mode == MODE_HIGHZ ? `PCMS_HIGHZ_MAX_HZ : `PCMS_IN1_MAX_HZ,
        o_range_max_hz);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // whole run is under two thousand cycles; this is far beyond it
  initial begin
    repeat (20000) @(posedge i_clk_sys);
    err_count++;
    $display("unexpected watchdog: expected end seen hang");
    complete_run();
  end

  initial begin
    i_rst         = 1'b1;
    i_carrier_khz = 32'h0000_0000;
    i_hold        = 1'b0;
    i_standby     = 1'b0;
    i_print_done  = 1'b0;
    i_addr        = 8'h00;
    i_wdata       = 32'h0000_0000;
    i_we          = 1'b0;
    i_re          = 1'b0;
    err_count     = 0;
    checks_done   = 0;
    m_mode        = MODE_AUTO;
    m_func        = FN_FREQ;
    void'($urandom(91));
    repeat (16) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    #1 chk("mode", MODE_AUTO, o_mode);
    chk("func", FN_FREQ, o_func);
    chk("suppress", 1'b1, o_suppress_low_digits);
    chk_range();
    rd(`PCMS_A_CTRL, rv);
    chk("ctrl", `PCMS_CTRL_RESET, rv);
    $display("test reset done");

    i_hold        <= 1'b1;
    i_carrier_khz <= $urandom;
    press(`PCMS_K_FREQ, 1);
    chk("msg", MSG_PROFILING, o_msg);
    op_u.burst(260, 40, 1);
    chk("msg", MSG_TABLE, o_msg);
    chk("locked", 1'b1, o_key_locked);
    press(`PCMS_K_WIDTH, 0);
    rd(`PCMS_A_SAMP_BASE, rv);
    chk("sample", i_carrier_khz, rv);
    @(posedge i_clk_sys);
    i_print_done <= 1'b1;
    @(posedge i_clk_sys);
    i_print_done <= 1'b0;
    @(posedge i_clk_sys);
    #1 chk("msg", MSG_NONE, o_msg);
    // second run by trigger key, plot output this time
    wr(`PCMS_A_CTRL, 32'h0000_0005);
    press(`PCMS_K_TRIG, 1);
    chk("msg", MSG_PROFILING, o_msg);
    op_u.burst(260, 40, 1);
    chk("msg", MSG_PLOT, o_msg);
    chk("locked", 1'b1, o_key_locked);
    @(posedge i_clk_sys);
    i_print_done <= 1'b1;
    @(posedge i_clk_sys);
    i_print_done <= 1'b0;
    @(posedge i_clk_sys);
    #1 chk("msg", MSG_NONE, o_msg);
    press(`PCMS_K_FREQ, 1);
    $display("test profile done");

    foreach (fk[i])
      press(fk[i], 1);
    $display("test functions done");
    foreach (mk[i]) begin
      press(mk[i], 1);
      chk_range();
    end
    $display("test modes done");

    h = $urandom_range(20, 3);
    fork
      op_u.burst(h, 25 - h, 12);
      begin
        repeat (260) @(posedge i_clk_sys);
        rd(`PCMS_A_RATE, rv);
        chk("rate", 36'h0_0000_0004, rv);
      end
    join
    rd(`PCMS_A_HIGH, rv);
    chk("high", h, rv);
    rd(`PCMS_A_GAP, rv);
    chk("gap", 25 - h, rv);
    rd(`PCMS_A_INTERVAL, rv);
    chk("interval", 36'h0_0000_0019, rv);
    $display("test timer done");

    wr(`PCMS_A_CTRL, 32'h0000_0000);
    op_u.set_det(1'b0);
    repeat (6) @(posedge i_clk_sys);
    #1 chk("active", 1'b0, o_meas_active);
    chk("suppress", 1'b0, o_suppress_low_digits);
    op_u.set_det(1'b1);
    repeat (6) @(posedge i_clk_sys);
    #1 chk("active", 1'b1, o_meas_active);
    rd(8'h18, rv);
    chk("unmapped", 36'h0_0000_0000, rv);
    $display("test force done");

    i_standby <= 1'b1;
    press(`PCMS_K_MANUAL, 0);
    chk("locked", 1'b1, o_key_locked);
    i_standby <= 1'b0;
    rd(`PCMS_A_CTRL, rv);
    chk("ctrl", 36'h0_0000_0000, rv);
    $display("test standby done");
    complete_run();
  end
endmodule
